/* File: verilog/pmsr_top.sv */
/*
  pmsr_top: mode, bias, calibration and seed registers behind an Avalon-MM slave,
  decoding mode bits into enables for the oscillator, buffers and output pins.
  assumes: one 250 MHz clock; chip_en, pll_locked and event inputs synchronous to it.
*/
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module pmsr_top (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  input  wire logic        chip_en,
  input  wire logic        pll_locked,
  input  wire logic        exact_freq_mode,
  input  wire logic        auto_seed_bit,
  input  wire logic        freq_change_pulse,
  input  wire logic        sync_trigger,
  output logic             osc_subsystem_gate,
  output logic             osc_core_en,
  output logic             ext_buf_en,
  output logic             loop_buf_en,
  output logic             ext_input_en,
  output logic             out1_pos_pin,
  output logic             out1_neg_pin,
  output logic             out2_pos_pin,
  output logic             out2_neg_pin,
  output logic             pump_pin_a,
  output logic             pump_pin_b,
  output logic      [1:0]  ext_bias,
  output logic      [23:0] bias_word,
  output logic      [23:0] cal_word,
  output logic      [23:0] phase_word,
  output logic             phase_load
);
  logic        rst_s1_reg;
  logic        rst_n;
  logic [23:0] modes_reg;
  logic [23:0] modes_next;
  logic [23:0] bias_reg;
  logic [23:0] bias_next;
  logic [23:0] cals_reg;
  logic [23:0] cals_next;
  logic [23:0] seed_reg;
  logic [23:0] seed_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  resp_reg;
  logic [1:0]  resp_next;
  logic [10:0] pin_next;
  logic [10:0] pin_reg;
  logic        mute;

  // merge byte lanes of a write into a 24-bit register; lane 3 has no bits
  function automatic logic [23:0] lane_merge(input logic [23:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // one wait state per access: the answer comes on the second edge
  always_comb begin
    modes_next = modes_reg;
    bias_next  = bias_reg;
    cals_next  = cals_reg;
    seed_next  = seed_reg;
    ack_next   = 1'b0;
    rdata_next = rdata_reg;
    resp_next  = 2'b00;
    if ((avs_read || avs_write) && !ack_reg) begin
      ack_next   = 1'b1;
      rdata_next = 32'h00000000;
      case (avs_address)
        pmsr_pkg::IDX_MODES: begin
          if (avs_write) modes_next = lane_merge(modes_reg, avs_writedata, avs_byteenable);
          rdata_next = {8'h00, modes_reg};
        end
        pmsr_pkg::IDX_BIAS: begin
          // values are software's job; stored verbatim
          if (avs_write) bias_next = lane_merge(bias_reg, avs_writedata, avs_byteenable);
          rdata_next = {8'h00, bias_reg};
        end
        pmsr_pkg::IDX_CALS: begin
          if (avs_write) cals_next = lane_merge(cals_reg, avs_writedata, avs_byteenable);
          rdata_next = {8'h00, cals_reg};
        end
        pmsr_pkg::IDX_SEED: begin
          if (avs_write) seed_next = lane_merge(seed_reg, avs_writedata, avs_byteenable);
          rdata_next = {8'h00, seed_reg};
        end
        pmsr_pkg::IDX_STATUS: begin
          rdata_next = {29'h00000000, mute, pll_locked, osc_subsystem_gate};
        end
        default: begin
          resp_next = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modes_reg <= pmsr_pkg::RST_MODES;
      bias_reg  <= pmsr_pkg::RST_BIAS;
      cals_reg  <= pmsr_pkg::RST_CALS;
      seed_reg  <= pmsr_pkg::RST_SEED;
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
      resp_reg  <= 2'b00;
    end else begin
      modes_reg <= modes_next;
      bias_reg  <= bias_next;
      cals_reg  <= cals_next;
      seed_reg  <= seed_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_response    = resp_reg;

  // pre-lock mute holds both ports quiet; registered so pins never glitch
  assign mute = modes_reg[pmsr_pkg::B_PRELOCK] && !pll_locked;

  always_comb begin
    logic gate;
    logic o1;
    logic o2;
    gate = modes_reg[pmsr_pkg::B_OSC_GATE] && chip_en;
    o1   = gate && modes_reg[pmsr_pkg::B_OUT1_EN] && !mute;
    o2   = gate && modes_reg[pmsr_pkg::B_OUT2_EN] && !mute;
    pin_next     = 11'h000;
    pin_next[0]  = gate;
    pin_next[1]  = gate && modes_reg[pmsr_pkg::B_OSC_EN];
    pin_next[2]  = gate && modes_reg[pmsr_pkg::B_EXT_BUF];
    pin_next[3]  = gate && modes_reg[pmsr_pkg::B_LOOP_BUF];
    pin_next[4]  = gate && modes_reg[pmsr_pkg::B_EXT_IN];
    pin_next[5]  = o1 && !modes_reg[pmsr_pkg::B_OUT1_SE];
    pin_next[6]  = o1;
    // single-ended port two keeps the negative pin, matching port one
    pin_next[7]  = o2 && !modes_reg[pmsr_pkg::B_OUT2_SE];
    pin_next[8]  = o2;
    pin_next[9]  = !modes_reg[pmsr_pkg::B_PUMP_SEL];
    pin_next[10] = modes_reg[pmsr_pkg::B_PUMP_SEL];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 11'h000;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign osc_subsystem_gate = pin_reg[0];
  assign osc_core_en        = pin_reg[1];
  assign ext_buf_en         = pin_reg[2];
  assign loop_buf_en        = pin_reg[3];
  assign ext_input_en       = pin_reg[4];
  assign out1_pos_pin       = pin_reg[5];
  assign out1_neg_pin       = pin_reg[6];
  assign out2_pos_pin       = pin_reg[7];
  assign out2_neg_pin       = pin_reg[8];
  assign pump_pin_a         = pin_reg[9];
  assign pump_pin_b         = pin_reg[10];
  assign ext_bias           = bias_reg[pmsr_pkg::B_BIAS_HI:pmsr_pkg::B_BIAS_LO];
  assign bias_word          = bias_reg;
  assign cal_word           = cals_reg;

  pmsr_seed_phase u_phase (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .seed              (seed_reg),
    .exact_freq_mode   (exact_freq_mode),
    .auto_seed_bit     (auto_seed_bit),
    .freq_change_pulse (freq_change_pulse),
    .sync_trigger      (sync_trigger),
    .phase_word        (phase_word),
    .phase_load        (phase_load)
  );
endmodule // pmsr_top
`default_nettype wire

/* File: inc/pmsr_pkg.sv */
/*
  pmsr_pkg: constants for the synthesizer mode, bias, calibration and seed register bank.
  assumes: a single 250 MHz clock domain and an Avalon-MM word-addressed slave.
*/
// Functional notes
// - modes bit 0 gates the oscillator subsystem, only while chip enable is high.
// - modes bit 2 enables the external oscillator buffer to the output stage.
// - modes bit 3 enables the internal loop buffer; it resets to one.
// - bit 4 enables output port one (reset 0), bit 5 port two (reset 1).
// - modes bit 6 enables the external oscillator input path; resets to zero.
// - bit 7 set keeps both output buffers muted until the loop reports lock.
// - bit 8: one drives only port one negative pin; zero drives both differentially.
// - bit 9: one is single-ended on port two; zero drives both pins.
// - bit 11 routes the charge pump to pin a when zero, pin b when one.
// - the 24-bit seed sets output phase to reference, with exact-frequency mode.
// - output phase equals two pi times seed over two to the 24th.
// - without exact mode and with auto seed set, seed sets start phase.
// - with auto seed clear, the seed reloads as start phase after each change.
package pmsr_pkg;
  localparam int          DATA_W       = 24;
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  IDX_MODES    = 5'h17;
  localparam logic [4:0]  IDX_BIAS     = 5'h18;
  localparam logic [4:0]  IDX_CALS     = 5'h19;
  localparam logic [4:0]  IDX_SEED     = 5'h1A;
  localparam logic [4:0]  IDX_STATUS   = 5'h1B;
  localparam logic [23:0] RST_MODES    = 24'h0001AB;
  localparam logic [23:0] RST_BIAS     = 24'h0054C1;
  localparam logic [23:0] RST_CALS     = 24'h000AAA;
  localparam logic [23:0] RST_SEED     = 24'hB29D0B;
  localparam int          B_OSC_GATE   = 0;
  localparam int          B_OSC_EN     = 1;
  localparam int          B_EXT_BUF    = 2;
  localparam int          B_LOOP_BUF   = 3;
  localparam int          B_OUT1_EN    = 4;
  localparam int          B_OUT2_EN    = 5;
  localparam int          B_EXT_IN     = 6;
  localparam int          B_PRELOCK    = 7;
  localparam int          B_OUT1_SE    = 8;
  localparam int          B_OUT2_SE    = 9;
  localparam int          B_PUMP_SEL   = 11;
  localparam int          B_BIAS_LO    = 19;
  localparam int          B_BIAS_HI    = 20;
endpackage

/* File: verilog/pmsr_seed_phase.sv */
/*
  pmsr_seed_phase: holds the modulator start phase and reloads it from the seed register.
  assumes: freq_change_pulse is one cycle wide, synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pmsr_seed_phase (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [23:0] seed,
  input  wire logic        exact_freq_mode,
  input  wire logic        auto_seed_bit,
  input  wire logic        freq_change_pulse,
  input  wire logic        sync_trigger,
  output logic      [23:0] phase_word,
  output logic             phase_load
);
  logic [23:0] phase_reg;
  logic [23:0] phase_next;
  logic        load_reg;
  logic        load_next;

  always_comb begin
    phase_next = phase_reg;
    load_next  = 1'b0;
    // phase = 2*pi*seed/2^24, so the seed is the phase word unscaled
    if (exact_freq_mode && sync_trigger) begin
      phase_next = seed;
      load_next  = 1'b1;
    end else if (!exact_freq_mode && !auto_seed_bit && freq_change_pulse) begin
      phase_next = seed;
      load_next  = 1'b1;
    end else if (!exact_freq_mode && auto_seed_bit) begin
      // start phase follows the seed directly, no reload event needed
      phase_next = seed;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= pmsr_pkg::RST_SEED;
      load_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      load_reg  <= load_next;
    end
  end

  assign phase_word = phase_reg;
  assign phase_load = load_reg;
endmodule // pmsr_seed_phase
`default_nettype wire

/* File: tb/pmsr_top_assertions.sv */
/* pmsr_checker: port checks of mode decode, bus wait state and phase load.
   assumes: bound to pmsr_top, one clock, arst_n async low. */
`timescale 1ns/100ps
`default_nettype none
module pmsr_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic chip_en,
  input wire logic exact_freq_mode,
  input wire logic sync_trigger,
  input wire logic osc_subsystem_gate,
  input wire logic ext_buf_en,
  input wire logic out1_pos_pin,
  input wire logic out1_neg_pin,
  input wire logic out2_pos_pin,
  input wire logic out2_neg_pin,
  input wire logic pump_pin_a,
  input wire logic pump_pin_b,
  input wire logic phase_load
);
  // outputs sit at reset values while the internal reset copy lifts
  logic [2:0] cnt_reg, cnt_next;
  logic       rdy;
  always_comb cnt_next = (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_next;
  end
  assign rdy = (cnt_reg == 3'h7);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_gate; rdy && osc_subsystem_gate |-> $past(chip_en); endproperty
  a_gate: assert property (p_gate) else $error("gate without chip enable");
  property p_ext; ext_buf_en |-> osc_subsystem_gate; endproperty
  a_ext: assert property (p_ext) else $error("ext buffer while gated off");
  property p_outen; out1_neg_pin || out2_neg_pin |-> osc_subsystem_gate; endproperty
  a_outen: assert property (p_outen) else $error("output while gated off");
  property p_o1; out1_pos_pin |-> out1_neg_pin; endproperty
  a_o1: assert property (p_o1) else $error("port one positive alone");
  property p_o2; out2_pos_pin |-> out2_neg_pin; endproperty
  a_o2: assert property (p_o2) else $error("port two positive alone");
  property p_pump; rdy |-> pump_pin_a != pump_pin_b; endproperty
  a_pump: assert property (p_pump) else $error("pump pins not exclusive");
  property p_wait; rdy && $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
  property p_sync; rdy && $past(exact_freq_mode && sync_trigger) |-> phase_load; endproperty
  a_sync: assert property (p_sync) else $error("no phase load on sync");
endmodule // pmsr_checker
bind pmsr_top pmsr_checker pmsr_checker_inst (.sys_clk, .arst_n, .avs_read, .avs_waitrequest,
  .chip_en, .exact_freq_mode, .sync_trigger, .osc_subsystem_gate, .ext_buf_en, .out1_pos_pin,
  .out1_neg_pin, .out2_pos_pin, .out2_neg_pin, .pump_pin_a, .pump_pin_b, .phase_load);
`default_nettype wire

/* File: tb/tb.sv */
/* tb: register bank bench with a behavioural register model.
   assumes: pmsr_top as the only design under test. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        sys_clk, arst_n, avs_read, avs_write, chip_en, pll_locked, phase_load;
  logic        exact_freq_mode, auto_seed_bit, freq_change_pulse, sync_trigger;
  logic        avs_waitrequest, osc_subsystem_gate, osc_core_en, ext_buf_en, loop_buf_en;
  logic        ext_input_en, out1_pos_pin, out1_neg_pin, out2_pos_pin, out2_neg_pin;
  logic        pump_pin_a, pump_pin_b;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rsp, ext_bias;
  logic [31:0] avs_writedata, avs_readdata, rd, lf;
  logic [23:0] bias_word, cal_word, phase_word;
  logic [23:0] mdl [4];
  int          errors, tests_run, cyc;
  pmsr_top pmsr_top_inst (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .chip_en, .pll_locked, .exact_freq_mode, .auto_seed_bit, .freq_change_pulse,
    .sync_trigger, .osc_subsystem_gate, .osc_core_en, .ext_buf_en, .loop_buf_en,
    .ext_input_en, .out1_pos_pin, .out1_neg_pin, .out2_pos_pin, .out2_neg_pin,
    .pump_pin_a, .pump_pin_b, .ext_bias, .bias_word, .cal_word, .phase_word, .phase_load);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      errors++;
    end
  endtask
  // one access; the model takes writes at the edge where waitrequest is seen low
  // request held until waitrequest is seen low at a rising edge; only the timeout ends a hang
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    if (wr && a >= 5'h17 && a <= 5'h1A)
      for (int b = 0; b < 3; b++) if (be[b]) mdl[a[1:0] + 2'h1][8*b +: 8] = d[8*b +: 8];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a);
    logic mp;
    mp = (a >= 5'h17 && a <= 5'h1A);
    bus(1'b0, a, 32'h0, 4'hF);
    chk("readdata", mp ? {8'h00, mdl[a[1:0] + 2'h1]} : 32'h0, rd);
    chk("response", mp ? 32'h0 : 32'h2, {30'h0, rsp});
  endtask
  task automatic pins();
    logic [23:0] m;
    logic        g, mu, o1, o2;
    // inputs driven just before the call must have settled before the expectation is formed
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    m = mdl[0];
    g = m[0] & chip_en;
    mu = m[7] & !pll_locked;
    o1 = g & m[4] & !mu;
    o2 = g & m[5] & !mu;
    chk("pins", {g, g & m[1], g & m[2], g & m[3], g & m[6], o1 & !m[8], o1, o2 & !m[9], o2,
      !m[11], m[11], mdl[1][20:19]}, {osc_subsystem_gate, osc_core_en, ext_buf_en,
      loop_buf_en, ext_input_en, out1_pos_pin, out1_neg_pin, out2_pos_pin, out2_neg_pin,
      pump_pin_a, pump_pin_b, ext_bias});
    chk("words", {mdl[1], 8'h00}, {bias_word, 8'h00});
    chk("cal_word", mdl[2], cal_word);
    bus(1'b0, 5'h1B, 32'h0, 4'hF);
    chk("status", {29'h0, mu, pll_locked, g}, rd);
    chk("status_resp", 32'h0, {30'h0, rsp});
  endtask
  task automatic ph(input logic ex, au, sy, fc, le);
    logic ld;
    exact_freq_mode <= ex;
    auto_seed_bit <= au;
    lf = lfsr(lf);
    bus(1'b1, 5'h1A, lf, 4'hF);
    @(posedge sys_clk);
    sync_trigger <= sy;
    freq_change_pulse <= fc;
    @(posedge sys_clk);
    sync_trigger <= 1'b0;
    freq_change_pulse <= 1'b0;
    ld = 1'b0;
    repeat (3) begin
      @(negedge sys_clk);
      ld = ld | (phase_load === 1'b1);
    end
    chk("phase_load", le, ld);
    chk("phase_word", mdl[3], phase_word);
    @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // a stuck handshake ends the run here
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    {arst_n, avs_read, avs_write, chip_en, pll_locked, exact_freq_mode} = 6'h00;
    {auto_seed_bit, freq_change_pulse, sync_trigger} = 3'h0;
    {avs_address, avs_writedata, avs_byteenable} = 41'h0;
    mdl = '{24'h0001AB, 24'h0054C1, 24'h000AAA, 24'hB29D0B};
    lf = 32'h02E4;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) rdchk(5'h17 + i[4:0]);
    rdchk(5'h05);
    chip_en <= 1'b1;
    pins();
    bus(1'b1, 5'h05, 32'hFFFFFF, 4'hF);
    rdchk(5'h05);
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      bus(1'b1, 5'h17 + i[4:0] % 5'h4, lf, lf[27:24]);
      rdchk(5'h17 + i[4:0] % 5'h4);
    end
    bus(1'b1, 5'h18, 32'h001854C3, 4'hF);
    bus(1'b1, 5'h19, 32'h00000AB2, 4'hF);
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      chip_en <= i[0] | lf[20];
      pll_locked <= i[1];
      bus(1'b1, 5'h17, lf, 4'hF);
      pins();
    end
    ph(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    ph(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    ph(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
